// >>> gio_far_end.sv
`timescale 1ns/1ps
module gio_far_end (
  // Clock
  input wire logic pclk,
  // Pin as the codec sees it
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_i,
  // Outside driver
  input wire logic ext_en,
  input wire logic ext_val
);
  logic float_q = 1'b0;
  // No pull on the wire, so a free pin wanders instead of holding
  always @(posedge pclk) float_q <= !float_q;
  assign pin_i = pin_oe ? pin_o : (ext_en ? ext_val : float_q);
endmodule

// >>> pin_irq_mux.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module pin_irq_mux import pin_irq_pkg::*; #(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event strobes from codec logic, one cycle each
  input wire logic ev_headset_insert,
  input wire logic ev_button_press,
  input wire logic ev_drc_left,
  input wire logic ev_drc_right,
  input wire logic ev_agc_left,
  input wire logic ev_agc_right,
  input wire logic ev_overcurrent_left,
  input wire logic ev_overcurrent_right,
  input wire logic ev_record_core_irq,
  input wire logic ev_playback_core_irq,
  input wire logic ev_dc_data_ready,
  // Host read of the interrupt flag registers
  input wire logic flag_reg_read,
  // Internal signals that may be routed to pins
  input wire logic divided_clock_output,
  input wire logic primary_data_out,
  input wire logic adc_word_clk,
  input wire logic sec_bit_clk,
  input wire logic sec_word_clk,
  input wire logic dmic_clk,
  // Interrupt lines
  output logic first_interrupt_line,
  output logic second_interrupt_line,
  // General I/O pin
  input wire logic general_io_pin_i,
  output logic general_io_pin_o,
  output logic general_io_pin_oe,
  output logic general_io_in_func,
  // Serial output pin
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  output logic serial_out_keeper_en
);

  // Whole module state
  typedef struct packed {
    logic [7:0] en1;
    logic [7:0] en2;
    gio_func_t gio_func;
    logic gio_val;
    logic so_keeper_dis;
    so_func_t so_func;
    logic so_val;
    logic gio_meta;
    logic gio_sync;
    line_t line1;
    line_t line2;
    logic [31:0] rdata;
    logic slverr;
    logic gio_o;
    logic gio_oe;
    logic gio_fwd;
    logic so_o;
    logic so_oe;
  } state_t;

  localparam line_t LINE_RESET = '{st: PL_IDLE, halt: 1'b0, cnt: '0};

  localparam state_t ST_RESET = '{
    en1: EN_RESET,
    en2: EN_RESET,
    gio_func: GIO_OFF,
    gio_val: VAL_RESET,
    so_keeper_dis: SO_KEEPER_RESET,
    so_func: SO_DATA,
    so_val: VAL_RESET,
    gio_meta: 1'b0,
    gio_sync: 1'b0,
    line1: LINE_RESET,
    line2: LINE_RESET,
    rdata: 32'h0000_0000,
    slverr: 1'b0,
    gio_o: 1'b0,
    gio_oe: 1'b0,
    gio_fwd: 1'b0,
    so_o: 1'b0,
    so_oe: 1'b0
  };

  // Pulse length at counter width; the default count fits in CNT_W bits
  localparam logic [CNT_W-1:0] LEN = CNT_W'(PULSE_LEN);

  // Registered state and its next value
  state_t st_q;
  state_t st_d;

  // Event vector, line triggers and bus decode
  logic [7:1] ev_vec;
  logic trig1;
  logic trig2;
  logic [IDX_W-1:0] idx;
  logic mapped;
  logic setup;
  logic wr_access;

  // OR of enabled sources; left and right share one enable
  function automatic logic any_enabled(input logic [7:0] en, input logic [7:1] ev);
    any_enabled = |(en[7:1] & ev);
  endfunction

  // A line is high only in the high phase of its generator
  function automatic logic line_high(input line_t ln);
    line_high = (ln.st == PL_HIGH);
  endfunction

  // One step of a pulse generator
  // High and low phases count down from LEN - 1 to zero
  function automatic line_t line_step(
    input line_t cur,
    input logic trig,
    input logic train,
    input logic stop
  );
    line_t nxt;
    nxt = cur;
    // A new event in the same cycle as a flag read wins over the stop;
    // a later event on a busy line is ignored and must not undo the read
    nxt.halt = cur.halt | (stop & ~trig); // [RL9]
    // Events in the high or low phase are dropped, so there is no retrigger
    case (cur.st)
      PL_IDLE: begin
        if (trig) begin
          nxt.st = PL_HIGH; // [RL20]
          nxt.cnt = LEN - 1'b1;
          nxt.halt = 1'b0;
        end
      end
      PL_HIGH: begin
        if (cur.cnt == '0) begin
          // Single mode ends here; train mode goes on unless halted
          if (train && !nxt.halt) begin // [RL9]
            nxt.st = PL_LOW;
            nxt.cnt = LEN - 1'b1;
          end else begin
            nxt.st = PL_IDLE; // [RL8]
          end
        end else begin
          nxt.cnt = cur.cnt - 1'b1;
        end
      end
      PL_LOW: begin
        // A flag read or a cleared mode bit ends the gap at once
        if (nxt.halt || !train) begin
          nxt.st = PL_IDLE; // [RL9]
        end else if (cur.cnt == '0) begin
          nxt.st = PL_HIGH;
          nxt.cnt = LEN - 1'b1;
        end else begin
          nxt.cnt = cur.cnt - 1'b1;
        end
      end
      default: begin
        nxt = LINE_RESET;
      end
    endcase
    return nxt;
  endfunction

  // Source vector in enable-bit order
  assign ev_vec[EN_HEADSET] = ev_headset_insert; // [RL1]
  assign ev_vec[EN_BUTTON] = ev_button_press; // [RL2]
  assign ev_vec[EN_DRC] = ev_drc_left | ev_drc_right; // [RL3]
  assign ev_vec[EN_AGC] = ev_agc_left | ev_agc_right; // [RL4]
  assign ev_vec[EN_OVC] = ev_overcurrent_left | ev_overcurrent_right; // [RL5]
  assign ev_vec[EN_CORE] = ev_record_core_irq | ev_playback_core_irq; // [RL6]
  assign ev_vec[EN_DC] = ev_dc_data_ready; // [RL7]

  // Each line has its own enables; both reset to zero so lines stay low
  assign trig1 = any_enabled(st_q.en1, ev_vec); // [RL19] [RL20]
  assign trig2 = any_enabled(st_q.en2, ev_vec); // [RL1] [RL2] [RL3] [RL4] [RL5] [RL6] [RL7] [RL20]

  // Bus decode; zero wait states so pready is constant high
  // Misaligned or out of range addresses answer with an error
  assign idx = paddr[ADDR_W-1:2];
  assign mapped = (paddr[1:0] == 2'b00) && (idx >= IDX_FIRST_IRQ) && (idx <= IDX_SO);
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite && mapped;
  assign pready = 1'b1;

  // Next state
  always_comb begin
    st_d = st_q;

    // Two-stage synchroniser for the pin input
    // Only the second stage is read, so a metastable first stage never spreads
    st_d.gio_meta = general_io_pin_i;
    st_d.gio_sync = st_q.gio_meta;

    // Register writes take effect in the access phase
    if (wr_access) begin
      case (idx)
        IDX_FIRST_IRQ: begin
          st_d.en1 = pwdata[7:0]; // [RL19]
        end
        IDX_SECOND_IRQ: begin
          st_d.en2 = pwdata[7:0];
        end
        IDX_GIO: begin
          // Reserved codes are stored but leave the pin disabled
          st_d.gio_func = gio_func_t'(pwdata[GIO_FUNC_MSB:GIO_FUNC_LSB]);
          st_d.gio_val = pwdata[GIO_VAL_BIT];
        end
        IDX_SO: begin
          st_d.so_keeper_dis = pwdata[SO_KEEPER_BIT];
          st_d.so_func = so_func_t'(pwdata[SO_FUNC_MSB:SO_FUNC_LSB]);
          st_d.so_val = pwdata[SO_VAL_BIT];
        end
        default: begin
          // Reserved locations ignore writes
        end
      endcase
    end

    // Read data captured in the setup phase, stable through access
    if (setup) begin
      st_d.rdata = 32'h0000_0000;
      st_d.slverr = !mapped;
      case (idx)
        IDX_FIRST_IRQ: begin
          st_d.rdata[7:0] = st_q.en1;
        end
        IDX_SECOND_IRQ: begin
          st_d.rdata[7:0] = st_q.en2;
        end
        IDX_GIO: begin
          st_d.rdata[GIO_FUNC_MSB:GIO_FUNC_LSB] = st_q.gio_func;
          st_d.rdata[GIO_STATE_BIT] = st_q.gio_sync; // [RL14]
          st_d.rdata[GIO_VAL_BIT] = st_q.gio_val;
        end
        IDX_SO: begin
          st_d.rdata[SO_KEEPER_BIT] = st_q.so_keeper_dis;
          st_d.rdata[SO_FUNC_MSB:SO_FUNC_LSB] = st_q.so_func;
          st_d.rdata[SO_VAL_BIT] = st_q.so_val;
        end
        default: begin
          // Reserved registers and bits read as zero
          st_d.rdata = 32'h0000_0000; // [RL10]
        end
      endcase
      // Unmapped reads clear the data so a stale value never leaks
      if (!mapped) begin
        st_d.rdata = 32'h0000_0000;
      end
    end

    // Pulse generators, one per interrupt line
    // One flag read strobe serves both lines, as the host read stops both trains
    st_d.line1 = line_step(st_q.line1, trig1, st_q.en1[PULSE_MODE], flag_reg_read); // [RL19]
    st_d.line2 = line_step(st_q.line2, trig2, st_q.en2[PULSE_MODE], flag_reg_read); // [RL8] [RL9]

    // General I/O pin; routed signals gain one cycle of latency
    // Undecoded codes never drive, so a stray write cannot fight an outside driver
    st_d.gio_o = 1'b0;
    st_d.gio_oe = 1'b0;
    st_d.gio_fwd = 1'b0;
    case (st_q.gio_func)
      GIO_OFF: begin
        st_d.gio_oe = 1'b0; // [RL11]
      end
      GIO_FUNC_IN: begin
        st_d.gio_fwd = st_q.gio_sync; // [RL11]
      end
      GIO_GP_IN: begin
        st_d.gio_oe = 1'b0; // [RL11] [RL14]
      end
      GIO_GP_OUT: begin
        st_d.gio_oe = 1'b1;
        st_d.gio_o = st_q.gio_val; // [RL15]
      end
      GIO_CLK_OUT: begin
        st_d.gio_oe = 1'b1;
        st_d.gio_o = divided_clock_output; // [RL12]
      end
      GIO_IRQ1: begin
        st_d.gio_oe = 1'b1;
        st_d.gio_o = line_high(st_q.line1); // [RL12]
      end
      GIO_IRQ2: begin
        st_d.gio_oe = 1'b1;
        st_d.gio_o = line_high(st_q.line2); // [RL12]
      end
      GIO_ADC_WCLK: begin
        st_d.gio_oe = 1'b1;
        st_d.gio_o = adc_word_clk; // [RL12]
      end
      GIO_SEC_BCLK: begin
        st_d.gio_oe = 1'b1;
        st_d.gio_o = sec_bit_clk; // [RL12]
      end
      GIO_SEC_WCLK: begin
        st_d.gio_oe = 1'b1;
        st_d.gio_o = sec_word_clk; // [RL12]
      end
      GIO_DMIC_CLK: begin
        st_d.gio_oe = 1'b1;
        st_d.gio_o = dmic_clk; // [RL12]
      end
      default: begin
        // Reserved codes: keep the pin off rather than guess
        st_d.gio_oe = 1'b0; // [RL13]
      end
    endcase

    // Serial output pin
    // Driven for every code but 000; the keeper enable follows its bit alone, whether the line is driven or released
    st_d.so_o = 1'b0;
    st_d.so_oe = 1'b1;
    case (st_q.so_func)
      SO_OFF: begin
        st_d.so_oe = 1'b0; // [RL17]
      end
      SO_DATA: begin
        st_d.so_o = primary_data_out; // [RL17]
      end
      SO_GP_OUT: begin
        st_d.so_o = st_q.so_val; // [RL18]
      end
      SO_CLK_OUT: begin
        st_d.so_o = divided_clock_output; // [RL17]
      end
      SO_IRQ1: begin
        st_d.so_o = line_high(st_q.line1); // [RL17]
      end
      SO_IRQ2: begin
        st_d.so_o = line_high(st_q.line2); // [RL17]
      end
      SO_SEC_BCLK: begin
        st_d.so_o = sec_bit_clk; // [RL17]
      end
      SO_SEC_WCLK: begin
        st_d.so_o = sec_word_clk; // [RL17]
      end
      default: begin
        st_d.so_oe = 1'b0;
      end
    endcase
  end

  // State register
  // Reset loads constants only; the synchroniser restarts low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs, all decoded from flip-flops
  // Pin enables come from registers, so a mode change cannot glitch a pin
  assign prdata = st_q.rdata;
  assign pslverr = st_q.slverr;
  assign first_interrupt_line = line_high(st_q.line1); // [RL19]
  assign second_interrupt_line = line_high(st_q.line2); // [RL8] [RL9]
  assign general_io_pin_o = st_q.gio_o;
  assign general_io_pin_oe = st_q.gio_oe;
  assign general_io_in_func = st_q.gio_fwd;
  assign serial_out_pin_o = st_q.so_o;
  assign serial_out_pin_oe = st_q.so_oe;
  assign serial_out_keeper_en = ~st_q.so_keeper_dis; // [RL16]

endmodule

// >>> pin_irq_mux_chk.sv
`timescale 1ns/1ps
module pin_irq_mux_chk import pin_irq_pkg::*; #(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Events and lines
  input wire logic ev_headset_insert,
  input wire logic ev_button_press,
  input wire logic first_interrupt_line,
  input wire logic second_interrupt_line,
  // Pins
  input wire logic general_io_pin_o,
  input wire logic general_io_pin_oe,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_pin_oe,
  input wire logic serial_out_keeper_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Saturated low count means idle; a train gap never reaches it
  localparam logic [CNT_W-1:0] SAT = CNT_W'(PULSE_LEN + 3);
  typedef struct packed {logic [7:0] en2; logic [CNT_W-1:0] hi1, hi2, lo2;} chk_t;
  chk_t s_q, s_d;
  logic wr, setup;
  assign wr = psel && penable && pwrite;
  assign setup = psel && !penable;
  // Shadow of second enable and run lengths
  always_comb begin
    s_d = s_q;
    if (wr && paddr == 8'hC4) s_d.en2 = pwdata[7:0];
    s_d.hi1 = first_interrupt_line ? s_q.hi1 + 1'b1 : '0;
    s_d.hi2 = second_interrupt_line ? s_q.hi2 + 1'b1 : '0;
    s_d.lo2 = second_interrupt_line ? '0 : (s_q.lo2 == SAT ? SAT : s_q.lo2 + 1'b1);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_q <= '{en2: 8'h00, hi1: '0, hi2: '0, lo2: SAT};
    else s_q <= s_d;
  end
  a_second_len: assert property ($fell(second_interrupt_line) |-> s_q.hi2 == CNT_W'(PULSE_LEN))
    else $error("second line pulse length wrong");
  a_first_len: assert property ($fell(first_interrupt_line) |-> s_q.hi1 == CNT_W'(PULSE_LEN))
    else $error("first line pulse length wrong");
  a_event_fires: assert property (s_q.lo2 == SAT && ((ev_headset_insert && s_q.en2[EN_HEADSET])
    || (ev_button_press && s_q.en2[EN_BUTTON])) |=> second_interrupt_line)
    else $error("enabled event did not fire");
  a_all_masked: assert property (s_q.lo2 == SAT && s_q.en2[7:1] == 7'h00 |=> !second_interrupt_line)
    else $error("line rose with no enable");
  a_keeper_bit: assert property (wr && paddr == 8'hD4 |=> serial_out_keeper_en != $past(pwdata[SO_KEEPER_BIT]))
    else $error("keeper enable wrong");
  a_gio_drive: assert property (wr && paddr == 8'hD0 && pwdata[5:2] == 4'h3
    |=> ##1 general_io_pin_oe && general_io_pin_o == $past(pwdata[GIO_VAL_BIT], 2))
    else $error("general pin output wrong");
  a_gio_quiet: assert property (wr && paddr == 8'hD0 && pwdata[5:2] inside {4'h0, 4'h1, 4'h2}
    |=> ##1 !general_io_pin_oe)
    else $error("general pin driven in input mode");
  a_so_drive: assert property (wr && paddr == 8'hD4 && pwdata[3:1] == 3'h2
    |=> ##1 serial_out_pin_oe && serial_out_pin_o == $past(pwdata[SO_VAL_BIT], 2))
    else $error("serial pin output wrong");
  a_so_off: assert property (wr && paddr == 8'hD4 && pwdata[3:1] == 3'h0 |=> ##1 !serial_out_pin_oe)
    else $error("serial pin driven while off");
  a_rsvd_zero: assert property (setup && paddr inside {8'hC8, 8'hCC} |=> prdata == 32'h0 && !pslverr)
    else $error("reserved read not zero");
endmodule

bind pin_irq_mux pin_irq_mux_chk #(.PULSE_LEN(PULSE_LEN)) pin_irq_mux_chk_inst (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .ev_headset_insert, .ev_button_press,
  .first_interrupt_line, .second_interrupt_line, .general_io_pin_o, .general_io_pin_oe,
  .serial_out_pin_o, .serial_out_pin_oe, .serial_out_keeper_en);

// >>> pin_irq_pkg.sv
// Functional notes
// (RL1) Headset insertion event fires second interrupt line only when its enable is set.
// (RL2) Button press event fires second interrupt line only when its enable is set.
// (RL3) Left or right compressor over-threshold fires second line when enabled.
// (RL4) Left or right gain-control noise detection fires second line when enabled.
// (RL5) Left or right headphone over-current fires second line when enabled.
// (RL6) Record or playback core interrupt fires second line when enabled.
// (RL7) New DC measurement data fires second line when enabled.
// (RL8) Pulse mode bit clear: one active-high pulse of about 2 ms per event.
// (RL9) Pulse mode bit set: repeated 2 ms pulses until host reads flag registers.
// (RL10) Host writes defaults to reserved locations; reserved bits read as zero.
// (RL11) General I/O codes 0..3: disabled, function input, general input, general output.
// (RL12) General I/O codes 4..10 route clock, interrupts and audio clocks to the pin.
// (RL13) Host must not program general I/O codes 11 to 15.
// (RL14) Read-only status bit shows the current general I/O pin level.
// (RL15) General output mode drives general I/O pin from value bit, reset 0.
// (RL16) Serial output keeper enabled when its bit is 0; bit resets to 1.
// (RL17) Serial output selector codes 0..7 route functions; reset code is primary data.
// (RL18) Serial output in general output mode drives its value bit, reset 0.
// (RL19) First interrupt line has its own identical enable register at index 0x30.
// (RL20) Any enabled event starts the pulse generator; all enables clear at reset.
package pin_irq_pkg;

  // Register indices; byte address is four times the index
  localparam int IDX_W = 6;
  localparam logic [5:0] IDX_FIRST_IRQ = 6'h30;
  localparam logic [5:0] IDX_SECOND_IRQ = 6'h31;
  localparam logic [5:0] IDX_RSVD_A = 6'h32;
  localparam logic [5:0] IDX_RSVD_B = 6'h33;
  localparam logic [5:0] IDX_GIO = 6'h34;
  localparam logic [5:0] IDX_SO = 6'h35;
  localparam int ADDR_W = 8;

  // Interrupt enable register fields
  localparam int EN_HEADSET = 7;
  localparam int EN_BUTTON = 6;
  localparam int EN_DRC = 5;
  localparam int EN_AGC = 4;
  localparam int EN_OVC = 3;
  localparam int EN_CORE = 2;
  localparam int EN_DC = 1;
  localparam int PULSE_MODE = 0;
  localparam logic [7:0] EN_RESET = 8'h00;

  // Pin control fields
  localparam int GIO_FUNC_MSB = 5;
  localparam int GIO_FUNC_LSB = 2;
  localparam int GIO_STATE_BIT = 1;
  localparam int GIO_VAL_BIT = 0;
  localparam int SO_KEEPER_BIT = 4;
  localparam int SO_FUNC_MSB = 3;
  localparam int SO_FUNC_LSB = 1;
  localparam int SO_VAL_BIT = 0;
  localparam logic SO_KEEPER_RESET = 1'b1;
  localparam logic VAL_RESET = 1'b0;

  // General I/O pin function codes
  typedef enum logic [3:0] {
    GIO_OFF = 4'h0, GIO_FUNC_IN = 4'h1, GIO_GP_IN = 4'h2, GIO_GP_OUT = 4'h3,
    GIO_CLK_OUT = 4'h4, GIO_IRQ1 = 4'h5, GIO_IRQ2 = 4'h6, GIO_ADC_WCLK = 4'h7,
    GIO_SEC_BCLK = 4'h8, GIO_SEC_WCLK = 4'h9, GIO_DMIC_CLK = 4'hA
  } gio_func_t;

  // Serial output pin function codes
  typedef enum logic [2:0] {
    SO_OFF = 3'h0, SO_DATA = 3'h1, SO_GP_OUT = 3'h2, SO_CLK_OUT = 3'h3,
    SO_IRQ1 = 3'h4, SO_IRQ2 = 3'h5, SO_SEC_BCLK = 3'h6, SO_SEC_WCLK = 3'h7
  } so_func_t;

  // Interrupt pulse timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned PULSE_TIME_NS = 2000000;
  localparam int unsigned PULSE_CYCLES = PULSE_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 20;

  // Pulse generator states
  typedef enum logic [1:0] {
    PL_IDLE = 2'b00,
    PL_HIGH = 2'b01,
    PL_LOW = 2'b10
  } line_state_t;

  typedef struct packed {
    line_state_t st;
    logic halt;
    logic [CNT_W-1:0] cnt;
  } line_t;

endpackage

// >>> tb.sv
`timescale 1ns/1ps
module tb import pin_irq_pkg::*;;
  localparam int unsigned PL = 8;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, gio_i, gio_o, gio_oe, in_func, so_o, so_oe, keep_en, irq1, irq2, v, k;
  logic [10:0] ev = '0;
  logic [5:0] src = '0;
  logic flag_rd = 1'b0, ext_en = 1'b0, ext_val = 1'b0;
  logic [1:0] e;
  int err_count = 0;
  int n_compared = 0;
  int n;
  always #2 pclk = ~pclk;
  pin_irq_mux #(.PULSE_LEN(PL)) pin_irq_mux_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev_headset_insert(ev[0]), .ev_button_press(ev[1]), .ev_drc_left(ev[2]),
    .ev_drc_right(ev[3]), .ev_agc_left(ev[4]), .ev_agc_right(ev[5]), .ev_overcurrent_left(ev[6]),
    .ev_overcurrent_right(ev[7]), .ev_record_core_irq(ev[8]), .ev_playback_core_irq(ev[9]),
    .ev_dc_data_ready(ev[10]), .flag_reg_read(flag_rd), .divided_clock_output(src[0]),
    .primary_data_out(src[1]), .adc_word_clk(src[2]), .sec_bit_clk(src[3]), .sec_word_clk(src[4]),
    .dmic_clk(src[5]), .first_interrupt_line(irq1), .second_interrupt_line(irq2),
    .general_io_pin_i(gio_i), .general_io_pin_o(gio_o), .general_io_pin_oe(gio_oe),
    .general_io_in_func(in_func), .serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe),
    .serial_out_keeper_en(keep_en));
  gio_far_end gio_far_end_inst (.pclk(pclk), .pin_o(gio_o), .pin_oe(gio_oe), .pin_i(gio_i),
    .ext_en(ext_en), .ext_val(ext_val));
  task automatic end_sim;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q,
                     output logic er);
    int w;
    w = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (w >= 50) err_count++;
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic er;
    apb(1'b1, a, d, q, er);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m, input logic xe);
    logic [31:0] q;
    logic er;
    apb(1'b0, a, 8'h00, q, er);
    cmp(q & {24'hFFFFFF, m}, {24'h0, x}, "read data");
    cmp(32'(er), 32'(xe), "slave error");
  endtask
  task automatic strobe(input logic [10:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= '0;
  endtask
  // Count high cycles of one line after waiting for it to rise
  task automatic count_hi(input logic first, output int c);
    int w;
    c = 0;
    w = 0;
    #1;
    while ((first ? irq1 : irq2) !== 1'b1 && w < 2 * PL + 4) begin
      @(posedge pclk);
      #1;
      w++;
    end
    while ((first ? irq1 : irq2) === 1'b1 && c < 4 * PL) begin
      @(posedge pclk);
      #1;
      c++;
    end
  endtask
  function automatic logic [10:0] ev_of(int b, logic r);
    case (b)
      7: ev_of = 11'h001;
      6: ev_of = 11'h002;
      5: ev_of = r ? 11'h008 : 11'h004;
      4: ev_of = r ? 11'h020 : 11'h010;
      3: ev_of = r ? 11'h080 : 11'h040;
      2: ev_of = r ? 11'h200 : 11'h100;
      default: ev_of = 11'h400;
    endcase
  endfunction
  function automatic logic [1:0] gio_exp(logic [3:0] c, logic val);
    case (c)
      4'h3: gio_exp = {1'b1, val};
      4'h4: gio_exp = {1'b1, src[0]};
      4'h5, 4'h6: gio_exp = 2'b10;
      4'h7: gio_exp = {1'b1, src[2]};
      4'h8: gio_exp = {1'b1, src[3]};
      4'h9: gio_exp = {1'b1, src[4]};
      4'hA: gio_exp = {1'b1, src[5]};
      default: gio_exp = 2'b00;
    endcase
  endfunction
  function automatic logic [1:0] so_exp(logic [2:0] c, logic val);
    case (c)
      3'h0: so_exp = 2'b00;
      3'h1: so_exp = {1'b1, src[1]};
      3'h2: so_exp = {1'b1, val};
      3'h3: so_exp = {1'b1, src[0]};
      3'h6: so_exp = {1'b1, src[3]};
      3'h7: so_exp = {1'b1, src[4]};
      default: so_exp = 2'b10;
    endcase
  endfunction
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    end_sim();
  end
  initial begin
    void'($urandom(10387));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    cmp(32'({so_oe, keep_en, irq2}), 32'h4, "reset pins");
    rd_chk(8'hC0, 8'h00, 8'hFF, 1'b0);
    rd_chk(8'hC4, 8'h00, 8'hFF, 1'b0);
    rd_chk(8'hD0, 8'h00, 8'hFD, 1'b0);
    rd_chk(8'hD4, 8'h12, 8'hFF, 1'b0);
    rd_chk(8'h00, 8'h00, 8'hFF, 1'b1);
    rd_chk(8'hC5, 8'h00, 8'hFF, 1'b1);
    wr_reg(8'hC8, 8'h00);
    rd_chk(8'hCC, 8'h00, 8'hFF, 1'b0);
    for (int b = 7; b >= 1; b--) begin
      v = 1'($urandom_range(1, 0));
      wr_reg(8'hC4, 8'hFE & ~(8'h01 << b));
      strobe(ev_of(b, v));
      count_hi(1'b0, n);
      cmp(32'(n), 32'h0, "masked event");
      wr_reg(8'hC4, 8'h01 << b);
      strobe(ev_of(b, v));
      count_hi(1'b0, n);
      cmp(32'(n), 32'(PL), "single pulse");
    end
    // Train: two pulses, then a flag read in the gap ends it
    wr_reg(8'hC4, 8'h03);
    strobe(11'h400);
    count_hi(1'b0, n);
    cmp(32'(n), 32'(PL), "train first");
    count_hi(1'b0, n);
    cmp(32'(n), 32'(PL), "train pulse");
    @(posedge pclk);
    flag_rd <= 1'b1;
    @(posedge pclk);
    flag_rd <= 1'b0;
    count_hi(1'b0, n);
    cmp(32'(n), 32'h0, "train stop");
    // Reset in mid pulse: line drops at once and the second line's enable register reads back cleared
    wr_reg(8'hC4, 8'h81);
    strobe(11'h001);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    cmp(32'({irq2, so_oe, keep_en}), 32'h0, "line in reset");
    @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(8'hC4, 8'h00, 8'hFF, 1'b0);
    rd_chk(8'hD4, 8'h12, 8'hFF, 1'b0);
    wr_reg(8'hC4, 8'h00);
    wr_reg(8'hC0, 8'h80);
    strobe(11'h001);
    count_hi(1'b1, n);
    cmp(32'(n), 32'(PL), "first line");
    // First line train: a flag read in the high phase lets the pulse finish,
    // and a later event on the busy line neither retriggers nor restarts it
    wr_reg(8'hC0, 8'h81);
    strobe(11'h001);
    @(posedge pclk);
    flag_rd <= 1'b1;
    @(posedge pclk);
    flag_rd <= 1'b0;
    strobe(11'h001);
    count_hi(1'b1, n);
    cmp(32'(n), 32'(PL - 4), "halted pulse tail");
    count_hi(1'b1, n);
    cmp(32'(n), 32'h0, "halted train");
    wr_reg(8'hC0, 8'h00);
    for (int c = 0; c <= 10; c++) begin
      v = 1'($urandom_range(1, 0));
      src <= 6'($urandom);
      wr_reg(8'hD0, {2'b00, 4'(c), 1'b0, v});
      repeat (3) @(posedge pclk);
      #1;
      e = gio_exp(4'(c), v);
      cmp(32'({gio_oe, gio_o & e[1]}), 32'(e), "general pin");
      rd_chk(8'hD0, {2'b00, 4'(c), 1'b0, v}, 8'hFD, 1'b0);
    end
    wr_reg(8'hD0, 8'h08);
    ext_en <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      ext_val <= i[0];
      repeat (4) @(posedge pclk);
      rd_chk(8'hD0, {6'h00, i[0], 1'b0}, 8'h02, 1'b0);
    end
    wr_reg(8'hD0, 8'h04);
    repeat (4) @(posedge pclk);
    #1;
    cmp(32'(in_func), 32'h1, "function input");
    @(posedge pclk);
    ext_val <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    cmp(32'(in_func), 32'h0, "function input low");
    for (int c = 0; c < 8; c++) begin
      v = 1'($urandom_range(1, 0));
      k = 1'($urandom_range(1, 0));
      src <= 6'($urandom);
      wr_reg(8'hD4, {3'b000, k, 3'(c), v});
      repeat (3) @(posedge pclk);
      #1;
      e = so_exp(3'(c), v);
      cmp(32'({so_oe, so_o & e[1]}), 32'(e), "serial pin");
      cmp(32'(keep_en), 32'(!k), "keeper");
      rd_chk(8'hD4, {3'b000, k, 3'(c), v}, 8'hFF, 1'b0);
    end
    end_sim();
  end
endmodule
